/* File: hdl/hqi_intake.sv */
`timescale 1ns/100ps
//Function
//- Clear slot request bit then raise irq when ring half empty or one free.
//- Head pointer word is host storage; device never touches it.
//- Resume trigger set: resume named work queue and clear trigger bit in the same cycle.
//- Resume naming queue zero is flagged as an erroneous request.
//- Master slot accepts entries before ring setup and while ring is full.
//- Ring holds host-set entry count, at least one, twelve bytes each.
//- Ring wraps; device takes entries strictly in slot order.
//- Go flag set: copy entry out, then clear go to free the slot.
//- Abort acknowledge flag passes to executor to end abort sequence.
//- Priority flag passes to executor for front-of-queue placement.
//- Remote fetch set: fetch from host memory, ignore other bits but go.
//- Host tag in words 2-3 passed back unchanged for onboard blocks.
//- Onboard: word 1 is parameter block offset in the window.
//- Remote: word 1 holds access types, words 2-3 host address.
//- Nonzero uninitialised work queue completes with uninitialised error.
//- Word 4 high byte is block length; zero means default for onboard.
//- Slot request flag is the top bit of the irq request register.
//- Irq uses vector bits 0-7 and level bits 8-10 of that register.
module hqi_intake (
   input  wire logic              CORE_CLK_I,
   input  wire logic              SYS_RST_I,
   input  wire logic              HOST_SEL_I,
   input  wire logic              HOST_WR_I,
   input  wire logic [9:0]        HOST_ADDR_I,
   input  wire logic [15:0]       HOST_WDATA_I,
   output logic [15:0]            HOST_RDATA_O,
   input  wire logic              RING_EN_I,
   input  wire logic [6:0]        RING_COUNT_I,
   input  wire logic [15:0]       WQ_INIT_I,
   output logic                   CMD_VALID_O,
   output hqi_pkg::hqi_cmd_t      CMD_O,
   input  wire logic              CMD_READY_I,
   output logic                   RESUME_O,
   output logic                   RESUME_ERR_O,
   output logic [3:0]             RESUME_QUEUE_O,
   output logic                   IRQ_O,
   output hqi_pkg::hqi_irq_t      IRQ_INFO_O
);
   import hqi_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_CLEAR} hqi_state_t;

   // =========================================================================
   // Host request synchroniser
   // =========================================================================
   hqi_host_req_t       h_meta;
   hqi_host_req_t       h_sync;
   logic                h_sel_d;
   logic                host_wr;
   logic                host_rd;

   always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         h_meta  <= '0;
         h_sync  <= '0;
         h_sel_d <= 1'b0;
      end else begin
         h_meta  <= '{HOST_SEL_I, HOST_WR_I, HOST_ADDR_I, HOST_WDATA_I};
         h_sync  <= h_meta;
         h_sel_d <= h_sync.sel;
      end
   end

   // One access per rising select, so a long strobe writes once
   assign host_wr = h_sync.sel & ~h_sel_d & h_sync.wr;
   assign host_rd = h_sync.sel & ~h_sel_d & ~h_sync.wr;

   // =========================================================================
   // Shared window memory
   // =========================================================================
   logic [15:0]         win [WIN_WORDS];
   logic                dev_we;
   logic [9:0]          dev_addr;
   logic [15:0]         dev_data;
   logic                dev_gnt;
   logic [15:0]         next_rdata;

   assign dev_gnt = ~host_wr;
   assign next_rdata = host_rd ? win[h_sync.addr] : HOST_RDATA_O;

   always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         HOST_RDATA_O <= 16'h0000;
      end else begin
         HOST_RDATA_O <= next_rdata;
      end
   end

   // Host write wins a collision; the device retries next cycle
   always_ff @(posedge CORE_CLK_I) begin
      if (host_wr) begin
         win[h_sync.addr] <= h_sync.wdata;
      end else if (dev_we) begin
         win[dev_addr] <= dev_data;
      end
   end

   // =========================================================================
   // Ring occupancy
   // =========================================================================
   function automatic logic [9:0] slot_base(input logic [5:0] s);
      slot_base = ADR_RING + 10'(s) * ENTRY_WORDS;
   endfunction

   logic [MAX_SLOTS-1:0] busy_vec;
   logic [6:0]           busy_cnt;
   logic [6:0]           free_cnt;

   generate
      for (genvar g = 0; g < MAX_SLOTS; g++) begin : g_busy
         assign busy_vec[g] = (7'(g) < RING_COUNT_I) &
                              win[slot_base(6'(g))][B_GO];
      end
   endgenerate

   always_comb begin
      busy_cnt = 7'h00;
      for (int i = 0; i < MAX_SLOTS; i++) begin
         busy_cnt = busy_cnt + 7'(busy_vec[i]);
      end
   end
   assign free_cnt = RING_COUNT_I - busy_cnt;

   // =========================================================================
   // Intake engine
   // =========================================================================
   hqi_state_t          state;
   hqi_state_t          next_state;
   logic [5:0]          ptr;
   logic [5:0]          next_ptr;
   logic [9:0]          cur_base;
   logic [9:0]          next_cur_base;
   logic                cur_master;
   logic                next_cur_master;
   logic                next_cmd_valid;
   hqi_cmd_t            next_cmd;
   logic [9:0]          cand_base;
   logic                cand_master;
   logic                cand_go;
   logic [15:0]         c_ctrl;
   logic [15:0]         c_qlen;
   logic                eng_we;
   logic                res_we;
   logic                irq_we;
   logic                next_resume;
   logic                next_resume_err;
   logic [3:0]          next_resume_q;
   logic                next_irq;
   logic                irq_fire;
   hqi_irq_t            next_irq_info;
   logic [15:0]         irq_word;
   logic [15:0]         res_word;

   assign irq_word = win[ADR_IRQ_REQ];
   assign res_word = win[ADR_RESUME];

   always_comb begin
      // Master slot first so it gets in even with a full ring
      cand_master = win[ADR_MASTER][B_GO];
      cand_base   = cand_master ? ADR_MASTER : slot_base(ptr);
      cand_go     = cand_master | (RING_EN_I & win[cand_base][B_GO]);
      c_ctrl      = win[cand_base + W_CTRL];
      c_qlen      = win[cand_base + W_QLEN];
   end

   always_comb begin
      next_state      = state;
      next_ptr        = ptr;
      next_cur_base   = cur_base;
      next_cur_master = cur_master;
      next_cmd_valid  = CMD_VALID_O;
      next_cmd        = CMD_O;
      eng_we          = 1'b0;
      case (state)
         ST_IDLE: begin
            if (cand_go) begin
               next_cur_base          = cand_base;
               next_cur_master        = cand_master;
               next_cmd.from_master   = cand_master;
               next_cmd.remote_fetch  = c_ctrl[B_REMOTE];
               // Remote entries carry only go as valid control
               next_cmd.abort_ack     = c_ctrl[B_ABORT_ACK] & ~c_ctrl[B_REMOTE];
               next_cmd.priority_flag = c_ctrl[B_PRIORITY] & ~c_ctrl[B_REMOTE];
               next_cmd.queue         = c_qlen[WQ_HI:0];
               next_cmd.length        = c_qlen[LEN_HI:LEN_LO];
               next_cmd.default_len   = (c_qlen[LEN_HI:LEN_LO] == 8'h00) &
                                        ~c_ctrl[B_REMOTE];
               next_cmd.uninit_err    = (c_qlen[WQ_HI:0] != 4'h0) &
                                        ((c_qlen[WQ_HI:0] > WQ_MAX) |
                                         ~WQ_INIT_I[c_qlen[WQ_HI:0]]);
               // Offset in window, or access types for remote
               next_cmd.locator       = win[cand_base + W_LOC];
               // Tag or host address, copied unaltered
               next_cmd.tag_or_addr   = {win[cand_base + W_TAGH], win[cand_base + W_TAGL]};
               next_cmd_valid         = 1'b1;
               next_state             = ST_ISSUE;
            end
         end
         ST_ISSUE: begin
            if (CMD_READY_I) begin
               next_cmd_valid = 1'b0;
               next_state     = ST_CLEAR;
            end
         end
         ST_CLEAR: begin
            eng_we = 1'b1;
            if (dev_gnt) begin
               // Wrap by the host-set count, minimum one entry
               if (!cur_master) begin
                  next_ptr = (7'(ptr) + 7'h01 >= RING_COUNT_I) ? 6'h00 : ptr + 6'h01;
               end
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // =========================================================================
   // Resume trigger and slot-free interrupt
   // =========================================================================
   always_comb begin
      next_resume     = 1'b0;
      next_resume_err = 1'b0;
      next_resume_q   = RESUME_QUEUE_O;
      // Raised one cycle after the request bit was written back clear
      next_irq        = irq_fire;
      next_irq_info   = IRQ_INFO_O;
      res_we          = 1'b0;
      irq_we          = 1'b0;
      dev_we          = 1'b0;
      dev_addr        = cur_base;
      dev_data        = win[cur_base] & ~(16'h0001 << B_GO);
      if (eng_we) begin
         dev_we = dev_gnt;
      end else if (res_word[B_TRIGGER]) begin
         res_we   = dev_gnt;
         dev_we   = dev_gnt;
         dev_addr = ADR_RESUME;
         dev_data = res_word & ~(16'h0001 << B_TRIGGER);
      end else if (irq_word[B_SLOT_REQ] &&
                   (irq_word[B_HALF_SEL] ? ({free_cnt, 1'b0} >= {1'b0, RING_COUNT_I})
                                         : (free_cnt != 7'h00))) begin
         irq_we   = dev_gnt;
         dev_we   = dev_gnt;
         dev_addr = ADR_IRQ_REQ;
         dev_data = irq_word & ~(16'h0001 << B_SLOT_REQ);
      end
      // The head pointer word never appears as a device address
      if (res_we) begin
         next_resume_q   = res_word[QN_HI:QN_LO];
         next_resume     = (res_word[QN_HI:QN_LO] != 4'h0);
         next_resume_err = (res_word[QN_HI:QN_LO] == 4'h0);
      end
      // Info latched with the clear; host may rewrite the word afterwards
      if (irq_we) begin
         next_irq_info.vector = irq_word[VEC_HI:0];
         next_irq_info.level  = irq_word[LVL_HI:LVL_LO];
      end
   end

   always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         state          <= ST_IDLE;
         ptr            <= 6'h00;
         cur_base       <= 10'h000;
         cur_master     <= 1'b0;
         CMD_VALID_O    <= 1'b0;
         CMD_O          <= '0;
         RESUME_O       <= 1'b0;
         RESUME_ERR_O   <= 1'b0;
         RESUME_QUEUE_O <= 4'h0;
         IRQ_O          <= 1'b0;
         irq_fire       <= 1'b0;
         IRQ_INFO_O     <= '0;
      end else begin
         state          <= next_state;
         ptr            <= next_ptr;
         cur_base       <= next_cur_base;
         cur_master     <= next_cur_master;
         CMD_VALID_O    <= next_cmd_valid;
         CMD_O          <= next_cmd;
         RESUME_O       <= next_resume;
         RESUME_ERR_O   <= next_resume_err;
         RESUME_QUEUE_O <= next_resume_q;
         IRQ_O          <= next_irq;
         irq_fire       <= irq_we;
         IRQ_INFO_O     <= next_irq_info;
      end
   end

endmodule // hqi_intake

/* File: shared/hqi_pkg.sv */
package hqi_pkg;

   // ==========================================================================
   // Shared window geometry (word addresses, 16-bit words)
   // ==========================================================================
   localparam int         WIN_AW        = 10;
   localparam int         WIN_WORDS     = 1024;
   localparam int         SLOT_AW       = 6;
   localparam int         MAX_SLOTS     = 64;
   localparam logic [9:0] ADR_IRQ_REQ   = 10'h004;
   localparam logic [9:0] ADR_HEAD_PTR  = 10'h005;
   localparam logic [9:0] ADR_RESUME    = 10'h006;
   localparam logic [9:0] ADR_MASTER    = 10'h008;
   localparam logic [9:0] ADR_RING      = 10'h040;
   localparam logic [9:0] ENTRY_WORDS   = 10'h006;

   // ==========================================================================
   // Entry word indices
   // ==========================================================================
   localparam logic [9:0] W_CTRL  = 10'h000;
   localparam logic [9:0] W_LOC   = 10'h001;
   localparam logic [9:0] W_TAGH  = 10'h002;
   localparam logic [9:0] W_TAGL  = 10'h003;
   localparam logic [9:0] W_QLEN  = 10'h004;

   // ==========================================================================
   // Field positions
   // ==========================================================================
   localparam int B_GO        = 0;
   localparam int B_ABORT_ACK = 1;
   localparam int B_PRIORITY  = 2;
   localparam int B_REMOTE    = 4;
   localparam int B_SLOT_REQ  = 15;
   localparam int B_HALF_SEL  = 14;
   localparam int B_TRIGGER   = 0;
   localparam int QN_LO       = 8;
   localparam int QN_HI       = 11;
   localparam int WQ_HI       = 3;
   localparam int LEN_LO      = 8;
   localparam int LEN_HI      = 15;
   localparam int VEC_HI      = 7;
   localparam int LVL_LO      = 8;
   localparam int LVL_HI      = 10;
   localparam int NUM_WQ      = 16;
   localparam logic [3:0] WQ_MAX = 4'he;

   typedef struct packed {
      logic        sel;
      logic        wr;
      logic [9:0]  addr;
      logic [15:0] wdata;
   } hqi_host_req_t;

   typedef struct packed {
      logic        from_master;
      logic        abort_ack;
      logic        priority_flag;
      logic        remote_fetch;
      logic        uninit_err;
      logic        default_len;
      logic [7:0]  length;
      logic [3:0]  queue;
      logic [15:0] locator;
      logic [31:0] tag_or_addr;
   } hqi_cmd_t;

   typedef struct packed {
      logic [7:0] vector;
      logic [2:0] level;
   } hqi_irq_t;

endpackage

/* File: sim/hqi_host_model.sv */
`timescale 1ns/100ps
module hqi_host_model (
   input  wire logic              clk_i,
   input  wire logic [15:0]       rdata_i,
   output hqi_pkg::hqi_host_req_t req_o
);
   import hqi_pkg::*;
   initial req_o = '0;
   task automatic access(input logic w, input logic [9:0] a, input logic [15:0] d,
                         output logic [15:0] q);
      @(posedge clk_i);
      req_o <= '{sel: 1'b1, wr: w, addr: a, wdata: d};
      repeat (5) @(posedge clk_i);
      q = rdata_i;
      // Released lines carry inverted junk, never the last value
      req_o <= '{sel: 1'b0, wr: ~w, addr: ~a, wdata: ~d};
      repeat (3) @(posedge clk_i);
   endtask
   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      logic [15:0] q;
      access(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [9:0] a, output logic [15:0] q);
      access(1'b0, a, 16'h0000, q);
   endtask
   task automatic post(input logic [9:0] b, input logic [15:0] c, w1, w2, w3, w4);
      logic [15:0] q;
      rd(b, q);
      while (q[0] === 1'b1) rd(b, q);
      wr(b + W_LOC, w1);
      wr(b + W_TAGH, w2);
      wr(b + W_TAGL, w3);
      wr(b + W_QLEN, w4);
      wr(b + 10'h005, 16'h0000);
      wr(b, c);
   endtask
endmodule // hqi_host_model

/* File: sim/hqi_intake_assertions.sv */
`timescale 1ns/100ps
module hqi_intake_chk (
   input  wire logic              CORE_CLK_I,
   input  wire logic              SYS_RST_I,
   input  wire logic [15:0]       WQ_INIT_I,
   input  wire logic              CMD_VALID_O,
   input  wire hqi_pkg::hqi_cmd_t CMD_O,
   input  wire logic              CMD_READY_I,
   input  wire logic              RESUME_O,
   input  wire logic              RESUME_ERR_O,
   input  wire logic [3:0]        RESUME_QUEUE_O,
   input  wire logic              IRQ_O
);
   import hqi_pkg::*;
   // ==========================================================================
   // Command handshake and command field flags
   // ==========================================================================
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (SYS_RST_I);
   sequence s_wait;
      CMD_VALID_O && !CMD_READY_I;
   endsequence
   sequence s_take;
      CMD_VALID_O && CMD_READY_I;
   endsequence
   AST_CMD_HOLD: assert property (s_wait |=> CMD_VALID_O && $stable(CMD_O))
      else $error("command dropped or changed before accept");
   AST_CMD_DONE: assert property (s_take |=> !CMD_VALID_O)
      else $error("command still offered after accept");
   AST_UNINIT: assert property (CMD_VALID_O && CMD_O.queue != 4'h0 && CMD_O.queue <= WQ_MAX
      |-> CMD_O.uninit_err == !WQ_INIT_I[CMD_O.queue]) else $error("uninit flag wrong");
   AST_WQ_ZERO: assert property (CMD_VALID_O && CMD_O.queue == 4'h0 |-> !CMD_O.uninit_err)
      else $error("queue zero flagged uninitialised");
   AST_DEF_LEN: assert property (CMD_VALID_O
      |-> CMD_O.default_len == (!CMD_O.remote_fetch && CMD_O.length == 8'h00))
      else $error("default length flag wrong");
   AST_REMOTE: assert property (CMD_VALID_O && CMD_O.remote_fetch
      |-> !CMD_O.abort_ack && !CMD_O.priority_flag) else $error("remote entry kept other bits");
   // ==========================================================================
   // Resume and interrupt pulses
   // ==========================================================================
   AST_RES_PULSE: assert property (RESUME_O |=> !RESUME_O)
      else $error("resume pulse too long");
   AST_RES_ZERO: assert property (RESUME_O |-> RESUME_QUEUE_O != 4'h0 && !RESUME_ERR_O)
      else $error("resume of queue zero");
   AST_IRQ_PULSE: assert property (IRQ_O |=> !IRQ_O)
      else $error("irq pulse too long");
endmodule // hqi_intake_chk

bind hqi_intake hqi_intake_chk u_chk (.CORE_CLK_I, .SYS_RST_I, .WQ_INIT_I, .CMD_VALID_O,
   .CMD_O, .CMD_READY_I, .RESUME_O, .RESUME_ERR_O, .RESUME_QUEUE_O, .IRQ_O);

/* File: sim/testbench.sv */
`timescale 1ns/100ps
module testbench;
   import hqi_pkg::*;
   logic          clk = 1'b0;
   logic          rst = 1'b1;
   logic          ring_en = 1'b0;
   logic          ready = 1'b0;
   logic [15:0]   rdata, q;
   logic          valid, res, res_err, irq;
   logic [3:0]    resq;
   hqi_host_req_t hreq;
   hqi_cmd_t      cmd, got;
   hqi_irq_t      irq_info;
   int            bad_count = 0, samples_checked = 0, n_res = 0, n_err = 0, n_irq = 0;
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      if (res === 1'b1) n_res++;
      if (res_err === 1'b1) n_err++;
      if (irq === 1'b1) n_irq++;
   end
   hqi_host_model host (.clk_i(clk), .rdata_i(rdata), .req_o(hreq));
   hqi_intake dut (.CORE_CLK_I(clk), .SYS_RST_I(rst), .HOST_SEL_I(hreq.sel),
      .HOST_WR_I(hreq.wr), .HOST_ADDR_I(hreq.addr), .HOST_WDATA_I(hreq.wdata),
      .HOST_RDATA_O(rdata), .RING_EN_I(ring_en), .RING_COUNT_I(7'h02),
      .WQ_INIT_I(16'h0004), .CMD_VALID_O(valid), .CMD_O(cmd), .CMD_READY_I(ready),
      .RESUME_O(res), .RESUME_ERR_O(res_err), .RESUME_QUEUE_O(resq), .IRQ_O(irq),
      .IRQ_INFO_O(irq_info));
   // ==========================================================================
   // Shared tasks
   // ==========================================================================
   task automatic chk(input string nm, input logic [79:0] exp, input logic [79:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic take(output hqi_cmd_t c);
      int n;
      n = 0;
      // Valid and command are seen as they stood just before this edge
      @(posedge clk);
      while (valid !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      c = cmd;
      ready <= 1'b1;
      @(posedge clk);
      ready <= 1'b0;
      // Let the accept edge pass so a following call sees valid low
      @(posedge clk);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ==========================================================================
   // Scenarios
   // ==========================================================================
   task automatic t_head;
      host.wr(ADR_HEAD_PTR, 16'h5a5a);
      host.rd(ADR_HEAD_PTR, q);
      chk("head pointer", 16'h5a5a, q);
   endtask
   task automatic t_master;
      host.post(ADR_MASTER, 16'h0007, 16'h0200, 16'hbeef, 16'h1234, 16'h0000);
      take(got);
      chk("master cmd", hqi_cmd_t'{1, 1, 1, 0, 0, 1, 0, 0, 16'h0200, 32'hbeef1234}, got);
      repeat (4) @(posedge clk);
      host.rd(ADR_MASTER, q);
      chk("master ctrl", 16'h0006, q);
   endtask
   task automatic t_ring;
      @(posedge clk) ring_en <= 1'b1;
      host.post(ADR_RING, 16'h0001, 16'h0300, 16'h1111, 16'h2222, 16'h0503);
      host.post(ADR_RING + ENTRY_WORDS, 16'h0017, 16'h0a3d, 16'h00ab, 16'hcdef, 16'h0002);
      take(got);
      chk("slot 0", hqi_cmd_t'{0, 0, 0, 0, 1, 0, 5, 3, 16'h0300, 32'h11112222}, got);
      take(got);
      chk("slot 1", hqi_cmd_t'{0, 0, 0, 1, 0, 0, 0, 2, 16'h0a3d, 32'h00abcdef}, got);
      host.post(ADR_RING, 16'h0001, 16'h0040, 16'h3333, 16'h4444, 16'h0000);
      take(got);
      chk("wrapped slot", hqi_cmd_t'{0, 0, 0, 0, 0, 1, 0, 0, 16'h0040, 32'h33334444}, got);
   endtask
   task automatic t_resume;
      host.wr(ADR_RESUME, 16'h0501);
      host.rd(ADR_RESUME, q);
      chk("resume word", 16'h0500, q);
      chk("resume pulses", 1, n_res);
      chk("resume queue", 4'h5, resq);
      host.wr(ADR_RESUME, 16'h0001);
      repeat (4) @(posedge clk);
      chk("resume errors", 1, n_err);
      chk("resume pulses", 1, n_res);
   endtask
   task automatic t_irq;
      host.wr(ADR_IRQ_REQ, 16'hc3a5);
      host.rd(ADR_IRQ_REQ, q);
      chk("irq word", 16'h43a5, q);
      chk("irq pulses", 1, n_irq);
      chk("irq info", {8'ha5, 3'h3}, irq_info);
      // Ring full: both slots busy while the executor stalls
      host.post(ADR_RING + ENTRY_WORDS, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
      host.post(ADR_RING, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
      host.wr(ADR_IRQ_REQ, 16'h8101);
      repeat (8) @(posedge clk);
      chk("irq while full", 1, n_irq);
      take(got);
      repeat (8) @(posedge clk);
      chk("irq after free", 2, n_irq);
      chk("irq info free", {8'h01, 3'h1}, irq_info);
      take(got);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      host.wr(ADR_MASTER, 16'h0000);
      host.wr(ADR_RING, 16'h0000);
      host.wr(ADR_RING + ENTRY_WORDS, 16'h0000);
      host.wr(ADR_IRQ_REQ, 16'h0000);
      host.wr(ADR_RESUME, 16'h0000);
      t_head;
      t_master;
      t_ring;
      t_resume;
      t_irq;
      tally_and_finish;
   end
   initial begin
      repeat (8000) @(posedge clk);
      bad_count++;
      tally_and_finish;
   end
endmodule // testbench
